//--- core/wdp_cfg.svh
`ifndef WDP_CFG_SVH
`define WDP_CFG_SVH

// option control register layout and reset value
`define WDP_OPT_RESET 8'h3F
`define WDP_OPT_IMPL_MASK 8'h3F
`define WDP_OPT_UNUSED 2'h0

// shared divider: all zeros after any reset
`define WDP_DIV_CLEAR 8'h00
`define WDP_DIV_STEP 8'h01

// watchdog counter
`define WDP_DOG_CLEAR 8'h00
`define WDP_DOG_STEP 8'h01
`define WDP_DOG_LAST 8'hFF
`define WDP_DOG_STEPS 256

// nominal undivided time-out and core clock rate
`define WDP_TIMEOUT_US 18000
`define WDP_CLK_MHZ 200
// undivided time-out rounds down: cycles of core_clk per watchdog step
`define WDP_TICK_CYCLES ((`WDP_TIMEOUT_US * `WDP_CLK_MHZ) / `WDP_DOG_STEPS)
`define WDP_TICK_W 24
`define WDP_TICK_ZERO 24'h000000
`define WDP_TICK_ONE 24'h000001

// fuse level that disables the watchdog for as long as the fuse input holds it
`define WDP_FUSE_OFF 1'b0

`endif

//--- core/wdp_pkg.sv
package wdp_pkg;

    // sleep tracking of the core
    typedef enum logic [1:0] {
        WDP_RUN = 2'h1,
        WDP_SLEEP = 2'h2
    } wdp_state_e;

    // option control register fields
    typedef struct packed {
        logic [1:0] unused;
        logic clk_src;
        logic edge_sel;
        logic divider_assign;
        logic [2:0] ratio_select;
    } wdp_option_s;

    // divider port bundle
    typedef struct packed {
        logic clear;
        logic step;
        logic [7:0] mask;
    } wdp_div_ctl_s;

endpackage : wdp_pkg

//--- core/wdp_divider.sv
`timescale 1ns/1ps
`include "wdp_cfg.svh"

module wdp_divider (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire wdp_pkg::wdp_div_ctl_s ctl,
    output logic [7:0] count,
    output logic wrap
);

    // wrap marks the step that completes one divided period
    assign wrap = ctl.step && ((count & ctl.mask) == ctl.mask);

    // clear beats step so a clear in the same cycle leaves zero
    always_ff @(posedge core_clk) begin
        if (!rst_n || ctl.clear) begin
            count <= `WDP_DIV_CLEAR;
        end else if (ctl.step) begin
            count <= count + `WDP_DIV_STEP;
        end
    end

endmodule : wdp_divider

//--- core/wdp_watchdog.sv
// Contract
// - watchdog runs from its own free-running oscillator tick
// - time-out resets device, also wakes from sleep
// - watchdog reset clears the active-low time-out flag
// - fuse at zero disables the watchdog forever; the logic disables it only while watchdog_enable_fuse reads zero
// - one divider serves timer or watchdog, never both
// - assign bit and ratio select set divider use
// - undivided 18 ms, divided up to 1:128
// - watchdog clear resets counter and assigned divider
// - sleep resets counter and assigned divider
// - upper option bits read zero, lower six reset to ones
// - assign bit low gives timer, high gives watchdog
// - divider hidden from software, zero after reset
`timescale 1ns/1ps
`include "wdp_cfg.svh"

module wdp_watchdog #(
    parameter int unsigned TICK_CYCLES = `WDP_TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic watchdog_enable_fuse,
    input wire logic option_wr,
    input wire logic [7:0] option_wdata,
    output logic [7:0] option_rdata,
    input wire logic watchdog_clear_instr,
    input wire logic sleep_instr,
    input wire logic timer_write,
    input wire logic timer_src_tick,
    output logic timer_inc,
    output logic dog_reset,
    output logic dog_wakeup,
    output logic timeout_flag_n,
    output logic asleep
);

    // mask of low divider bits that must be all ones to wrap
    function automatic logic [7:0] ratio_mask(
        input logic [2:0] ratio,
        input logic to_dog
    );
        logic [8:0] span;
        span = to_dog ? (9'h001 << ratio) : (9'h002 << ratio);
        ratio_mask = 8'(span - 9'h001);
    endfunction : ratio_mask

    wdp_pkg::wdp_option_s opt;
    wdp_pkg::wdp_state_e state;
    wdp_pkg::wdp_state_e next_state;
    wdp_pkg::wdp_div_ctl_s div_ctl;
    logic [`WDP_TICK_W-1:0] tick_cnt;
    logic [7:0] watchdog_counter;
    logic [7:0] div_count;
    logic clr_pend;
    logic div_wrap;

    wire div_to_dog = opt.divider_assign;
    wire [2:0] ratio = opt.ratio_select;
    wire [7:0] dog_mask = ratio_mask(ratio, 1'b1);
    wire [7:0] tmr_mask = ratio_mask(ratio, 1'b0);
    wire fuse_on = (watchdog_enable_fuse != `WDP_FUSE_OFF);
    // a watchdog reset restarts everything but the oscillator tick, the time-out flag and the reset and wake pulses
    wire dev_rst_n = rst_n && !dog_reset;
    wire tick_last = (tick_cnt == `WDP_TICK_W'(TICK_CYCLES - 1));
    wire osc_tick = tick_last;
    wire clr_req = watchdog_clear_instr || sleep_instr;
    wire dog_clr = osc_tick && clr_pend;
    wire ovf = osc_tick && !dog_clr && fuse_on &&
        (watchdog_counter == `WDP_DOG_LAST);
    wire timeout = fuse_on && (div_to_dog ? div_wrap : ovf);
    wire next_clr_pend = clr_req || (clr_pend && !osc_tick);

    // free-running oscillator stand-in: one step enable per period
    always_ff @(posedge core_clk) begin
        if (!rst_n || tick_last) begin
            tick_cnt <= `WDP_TICK_ZERO;
        end else begin
            tick_cnt <= tick_cnt + `WDP_TICK_ONE;
        end
    end

    // requests wait for the next oscillator step; a new one wins
    // over the retire so a request never gets lost
    always_ff @(posedge core_clk) begin
        if (!dev_rst_n) begin
            clr_pend <= 1'b0;
        end else begin
            clr_pend <= next_clr_pend;
        end
    end

    // watchdog counter steps only on the oscillator enable
    always_ff @(posedge core_clk) begin
        if (!dev_rst_n || dog_clr) begin
            watchdog_counter <= `WDP_DOG_CLEAR;
        end else if (osc_tick) begin
            watchdog_counter <= watchdog_counter + `WDP_DOG_STEP;
        end
    end

    // divider steering: watchdog overflow or timer source
    assign div_ctl.step = div_to_dog ? ovf : timer_src_tick;
    assign div_ctl.clear = div_to_dog ? dog_clr : timer_write;
    assign div_ctl.mask = div_to_dog ? dog_mask : tmr_mask;

    wdp_divider u_divider (
        .core_clk(core_clk),
        .rst_n(dev_rst_n),
        .ctl(div_ctl),
        .count(div_count),
        .wrap(div_wrap)
    );

    // timer is undivided while the watchdog owns the divider
    assign timer_inc = div_to_dog ? timer_src_tick : div_wrap;

    // option register: read back on option_rdata, upper bits forced to zero
    always_ff @(posedge core_clk) begin
        if (!dev_rst_n) begin
            opt <= `WDP_OPT_RESET;
        end else if (option_wr) begin
            opt <= option_wdata & `WDP_OPT_IMPL_MASK;
        end
    end
    assign option_rdata = opt;

    // reset pulse lasts one cycle; sleep is remembered for wake
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dog_reset <= 1'b0;
            dog_wakeup <= 1'b0;
        end else begin
            dog_reset <= timeout && !dog_reset;
            dog_wakeup <= timeout && !dog_reset && asleep;
        end
    end

    // time-out flag: cleared by watchdog reset, set by clear or sleep
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timeout_flag_n <= 1'b1;
        end else if (dog_reset) begin
            timeout_flag_n <= 1'b0;
        end else if (clr_req) begin
            timeout_flag_n <= 1'b1;
        end
    end

    // run / sleep tracking
    always_comb begin
        next_state = state;
        unique case (state)
            wdp_pkg::WDP_RUN: begin
                if (sleep_instr) begin
                    next_state = wdp_pkg::WDP_SLEEP;
                end
            end
            wdp_pkg::WDP_SLEEP: begin
                next_state = wdp_pkg::WDP_SLEEP;
            end
            default: begin
                next_state = wdp_pkg::WDP_RUN;
            end
        endcase
    end

    // any reset, including the watchdog's own, returns to run
    always_ff @(posedge core_clk) begin
        if (!dev_rst_n) begin
            state <= wdp_pkg::WDP_RUN;
        end else begin
            state <= next_state;
        end
    end
    assign asleep = (state == wdp_pkg::WDP_SLEEP);

    // checks on the design's own outputs and state
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    osc_gap_a: assert property (
        osc_tick |=> !osc_tick
    ) else $error("oscillator step not one cycle wide");

    wake_reset_a: assert property (
        (asleep && timeout && !dog_reset) |=> (dog_reset && dog_wakeup)
    ) else $error("sleep time-out did not wake the device");

    reset_pulse_a: assert property (
        dog_reset |=> !dog_reset
    ) else $error("watchdog reset longer than one cycle");

    flag_clear_a: assert property (
        dog_reset |=> !timeout_flag_n
    ) else $error("time-out flag not cleared by watchdog reset");

    fuse_off_a: assert property (
        (watchdog_enable_fuse == `WDP_FUSE_OFF) |=> !dog_reset
    ) else $error("reset fired with watchdog fused off");

    undiv_timer_a: assert property (
        div_to_dog |-> (timer_inc == timer_src_tick)
    ) else $error("timer divided while watchdog owns divider");

    timer_clear_a: assert property (
        (timer_write && !div_to_dog && !dog_reset) |=> (div_count == 8'h00)
    ) else $error("timer write did not clear divider");

    opt_write_a: assert property (
        (option_wr && !dog_reset && !timeout) |=>
            (option_rdata == ($past(option_wdata) & `WDP_OPT_IMPL_MASK))
    ) else $error("option write not stored");

    undiv_dog_a: assert property (
        (!div_to_dog && ovf && !dog_reset) |=> dog_reset
    ) else $error("undivided overflow gave no reset");

    clear_count_a: assert property (
        (dog_clr && !dog_reset) |=>
            (watchdog_counter == 8'h00 &&
             ($past(div_to_dog) ? div_count == 8'h00 : 1'b1))
    ) else $error("watchdog clear left counts standing");

    sleep_entry_a: assert property (
        (sleep_instr && !dog_reset && !timeout) |=> asleep
    ) else $error("sleep not recorded");

    opt_reset_a: assert property (
        dog_reset |=> (option_rdata == `WDP_OPT_RESET)
    ) else $error("option not restored by watchdog reset");

    opt_upper_a: assert property (
        option_rdata[7:6] == `WDP_OPT_UNUSED
    ) else $error("unimplemented option bits not zero");

    div_zero_a: assert property (
        dog_reset |=> (div_count == 8'h00)
    ) else $error("divider not zero after reset");

    post_wrap_a: assert property (
        (div_to_dog && ovf && fuse_on && !dog_reset &&
            ((div_count & dog_mask) == dog_mask)) |=> dog_reset
    ) else $error("postscaled time-out missed");

    pend_set_a: assert property (
        (watchdog_clear_instr && !dog_reset) |=> clr_pend
    ) else $error("clear request lost");

endmodule : wdp_watchdog

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
    localparam int TK = 4;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic watchdog_enable_fuse = 1'b1;
    logic option_wr = 1'b0;
    logic [7:0] option_wdata = 8'h00;
    logic watchdog_clear_instr = 1'b0;
    logic sleep_instr = 1'b0;
    logic timer_write = 1'b0;
    logic timer_src_tick = 1'b0;
    logic [7:0] option_rdata;
    logic timer_inc;
    logic dog_reset;
    logic dog_wakeup;
    logic timeout_flag_n;
    logic asleep;
    logic wake;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int rst_cnt = 0;
    int inc_cnt = 0;
    int n = 0;
    int base = 0;

    // short tick keeps every time-out within a few thousand cycles
    wdp_watchdog #(.TICK_CYCLES(TK)) i_wdp_watchdog (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .watchdog_enable_fuse(watchdog_enable_fuse),
        .option_wr(option_wr),
        .option_wdata(option_wdata),
        .option_rdata(option_rdata),
        .watchdog_clear_instr(watchdog_clear_instr),
        .sleep_instr(sleep_instr),
        .timer_write(timer_write),
        .timer_src_tick(timer_src_tick),
        .timer_inc(timer_inc),
        .dog_reset(dog_reset),
        .dog_wakeup(dog_wakeup),
        .timeout_flag_n(timeout_flag_n),
        .asleep(asleep)
    );

    always #2.5 core_clk = ~core_clk;

    // hang guard and count of time-out pulses
    always @(posedge core_clk) begin
        cyc++;
        if (dog_reset === 1'b1) rst_cnt++;
        if (cyc > 40000) begin
            err_count++;
            summarize();
        end
    end

    task summarize;
        $display("mismatches %0d comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task chk_rng(input string what, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng

    // one-cycle pulse: 0 option, 1 clear, 2 sleep, 3 timer write, 4 tick
    task pulse(input int k, input logic [7:0] d);
        @(negedge core_clk);
        option_wdata = d;
        option_wr = (k == 0);
        watchdog_clear_instr = (k == 1);
        sleep_instr = (k == 2);
        timer_write = (k == 3);
        timer_src_tick = (k == 4);
        #1;
        if (k == 4 && timer_inc === 1'b1) inc_cnt++;
        @(negedge core_clk);
        option_wr = 1'b0;
        watchdog_clear_instr = 1'b0;
        sleep_instr = 1'b0;
        timer_write = 1'b0;
        timer_src_tick = 1'b0;
    endtask : pulse

    // bounded wait for a time-out, cycles counted from the call
    task wait_to(input int lim);
        n = 0;
        while (dog_reset !== 1'b1 && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        wake = dog_wakeup;
    endtask : wait_to

    initial begin
        repeat (5) @(negedge core_clk);
        chk("option", 8'h3F, option_rdata);
        chk("flag", 1, timeout_flag_n);
        chk("asleep", 0, asleep);
        rst_n = 1'b1;
        pulse(0, 8'hFF);
        chk("option", 8'h3F, option_rdata);
        pulse(0, 8'hC5);
        chk("option", 8'h05, option_rdata);
        // divider to watchdog, ratios 1:1, 1:2, 1:4
        for (int r = 0; r < 3; r++) begin
            pulse(0, {5'b00001, r[2:0]});
            pulse(1, 8'h00);
            wait_to(20000);
            chk_rng("period", (256 << r) * TK - TK, (256 << r) * TK + TK + 2, n);
            chk("wakeup", 0, wake);
            @(negedge core_clk);
            chk("flag", 0, timeout_flag_n);
            chk("option", 8'h3F, option_rdata);
        end
        // divider on timer: ratio must not stretch the watchdog
        pulse(0, 8'h07);
        pulse(1, 8'h00);
        wait_to(20000);
        chk_rng("undivided", 256 * TK - TK, 256 * TK + TK + 2, n);
        // regular clears hold off a 1024-cycle time-out
        pulse(0, 8'h00);
        base = rst_cnt;
        repeat (6) begin
            pulse(1, 8'h00);
            chk("flag", 1, timeout_flag_n);
            repeat (600) @(negedge core_clk);
        end
        chk("resets", base, rst_cnt);
        // sleep then wake by time-out
        pulse(0, 8'h08);
        pulse(2, 8'h00);
        @(negedge core_clk);
        chk("asleep", 1, asleep);
        wait_to(20000);
        chk_rng("sleep", 256 * TK - TK, 256 * TK + TK + 2, n);
        chk("wakeup", 1, wake);
        @(negedge core_clk);
        chk("asleep", 0, asleep);
        // fuse off: no time-out at all
        pulse(0, 8'h00);
        watchdog_enable_fuse = 1'b0;
        base = rst_cnt;
        repeat (3000) @(negedge core_clk);
        chk("resets", base, rst_cnt);
        watchdog_enable_fuse = 1'b1;
        // clear first, then hand the divider to the timer
        pulse(1, 8'h00);
        pulse(0, 8'h00);
        pulse(3, 8'h00);
        inc_cnt = 0;
        repeat (8) pulse(4, 8'h00);
        chk("incs", 4, inc_cnt);
        pulse(0, 8'h01);
        pulse(3, 8'h00);
        repeat (2) pulse(4, 8'h00);
        pulse(3, 8'h00);
        inc_cnt = 0;
        repeat (3) pulse(4, 8'h00);
        chk("incs", 0, inc_cnt);
        pulse(4, 8'h00);
        chk("incs", 1, inc_cnt);
        pulse(0, 8'h08);
        inc_cnt = 0;
        repeat (5) pulse(4, 8'h00);
        chk("incs", 5, inc_cnt);
        summarize();
    end
endmodule : tb
